/* hw/clts_pkg.sv */
package clts_pkg;
    // register byte offsets on the apb slave
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_LENGTH    = 8'h04;
    localparam logic [7:0] OFF_DELAY     = 8'h08;
    localparam logic [7:0] OFF_TOL       = 8'h0c;
    localparam logic [7:0] OFF_STATUS    = 8'h10;
    localparam logic [7:0] OFF_POSITION  = 8'h14;
    localparam logic [7:0] OFF_SPEED     = 8'h18;
    localparam logic [7:0] OFF_TARGET    = 8'h1c;
    localparam logic [7:0] OFF_STOPADJ   = 8'h20;
    localparam logic [7:0] OFF_DECEL     = 8'h24;
    localparam logic [7:0] OFF_OVERSHOOT = 8'h28;

    // control register fields
    localparam int CTRL_SPEED_COMP = 0;
    localparam int CTRL_ADAPT_SLOW = 1;
    localparam int CTRL_REMOTE_RUN = 2;
    localparam int CTRL_TYPE_LSB   = 4;
    localparam int CTRL_TYPE_W     = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // machine type codes from the configuration switches
    localparam logic [1:0] TYPE_FLYING   = 2'h0;
    localparam logic [1:0] TYPE_STOP_1SP = 2'h1;
    localparam logic [1:0] TYPE_STOP_2SP = 2'h2;
    localparam logic [1:0] TYPE_FLY_2SP  = 2'h3;

    // reset values
    localparam logic [31:0] LENGTH_RESET  = 32'h0000_03e8;
    localparam logic [15:0] DELAY_RESET   = 16'h0000;
    localparam logic [15:0] TOL_RESET     = 16'h0004;
    localparam logic [15:0] DECEL_RESET   = 16'h0010;

    // speed sampling window: 1 ms at 250 MHz
    localparam int SYS_CLK_MHZ       = 250;
    localparam int SAMPLE_US         = 1000;
    localparam int SAMPLE_CYCLES     = SAMPLE_US * SYS_CLK_MHZ;
    localparam int SAMPLE_CW         = 18;

    typedef enum logic [2:0] {
        CLTS_HALT,
        CLTS_RUN_FAST,
        CLTS_RUN_SLOW,
        CLTS_STOPPING,
        CLTS_SETTLE
    } clts_state_t;
endpackage : clts_pkg

/* hw/clts_top.sv */
// Overview of operation
// R1 - without compensation a shear pulse fires each time the count passes one part length.
// R2 - with speed compensation each shear target is pulled in by speed times press delay.
// R3 - on feed-to-stop machines the stop is issued early by speed times stopping delay.
// R4 - after each feed move the stop error is measured and the stop advance is trimmed.
// R5 - a programmed tolerance decides whether the stop was accurate and whether to learn.
// R6 - adaptive slow-down shifts to creep at a point computed from speed and deceleration; the code shifts only on feed-to-stop machines.
// R7 - on feed-to-stop machines a manual cycle is allowed only in halt.
// R8 - on flying machines a manual crop cut is allowed while running.
// R9 - automatic shear firing happens only in run mode.
// R10 - emergency stop or overload forces halt.
// R11 - run and halt come from the panel or a remote contact, per configuration.
// R12 - sequencing follows the machine type setting.
// R13 - halt stops production and returns to manual mode, local or remote.
// R14 - run enters automatic mode unless remote run makes the panel button ignored.
// R15 - jog requests are honoured only in manual mode.
// R16 - line speed is counts per fixed sampling window, refreshed every window.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module clts_top #(
    parameter int SAMPLE_CYCLES = clts_pkg::SAMPLE_CYCLES
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        ENC_STEP_IN,
    input  wire logic        ENC_DIR_IN,
    input  wire logic        RUN_BTN_IN,
    input  wire logic        HALT_BTN_IN,
    input  wire logic        CYCLE_BTN_IN,
    input  wire logic        REMOTE_RUN_IN,
    input  wire logic        REMOTE_HALT_IN,
    input  wire logic        ESTOP_IN,
    input  wire logic        OVERLOAD_IN,
    input  wire logic        JOG_FWD_IN,
    input  wire logic        JOG_REV_IN,
    output logic             SHEAR_OUT,
    output logic             RUN_OUT,
    output logic             FWD_OUT,
    output logic             SLOW_OUT,
    output logic             REV_OUT
);
    clts_pkg::clts_state_t state_r;
    logic [31:0] ctrl_r;
    logic [31:0] length_r;
    logic [15:0] delay_r;
    logic [15:0] tol_r;
    logic [15:0] decel_r;
    logic [31:0] pos_r;
    logic [31:0] base_r;
    logic [15:0] speed_r;
    localparam int SAMPLE_CW_W = clts_pkg::SAMPLE_CW;
    logic [15:0] win_cnt_r;
    logic [SAMPLE_CW_W-1:0] tick_r;
    logic [31:0] stopadj_r;
    logic [31:0] over_r;
    logic        accurate_r;
    logic        btn_q_r;

    logic [1:0]  mtype;
    logic        stop_type;
    logic        two_speed;
    logic        run_cmd;
    logic        halt_cmd;
    logic        fault;
    logic        in_run;
    logic [31:0] nominal;
    logic [31:0] target;
    logic [31:0] slow_pt;
    logic        cycle_ok;
    logic        cycle_edge;
    logic        setup;
    logic        access;

    // scaled product of speed and a delay or decel figure, used in two places
    function automatic logic [31:0] clts_scale(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] p;
        p = a * b;
        return {8'h00, p[31:8]};
    endfunction

    // machine type decode
    assign mtype     = ctrl_r[clts_pkg::CTRL_TYPE_LSB +: clts_pkg::CTRL_TYPE_W];
    assign stop_type = (mtype == clts_pkg::TYPE_STOP_1SP) || (mtype == clts_pkg::TYPE_STOP_2SP); // R12
    assign two_speed = (mtype == clts_pkg::TYPE_STOP_2SP) || (mtype == clts_pkg::TYPE_FLY_2SP); // R12

    // command sources: panel run dropped under remote run, halt from either source
    assign run_cmd  = ctrl_r[clts_pkg::CTRL_REMOTE_RUN] ? REMOTE_RUN_IN : RUN_BTN_IN; // R11 R14
    assign halt_cmd = HALT_BTN_IN | REMOTE_HALT_IN; // R13
    assign fault    = ESTOP_IN | OVERLOAD_IN;
    assign in_run   = (state_r != clts_pkg::CLTS_HALT);

    // targets: nominal next cut, pulled in by speed times delay
    assign nominal = base_r + length_r;
    assign target  = ctrl_r[clts_pkg::CTRL_SPEED_COMP] || stop_type
                   ? nominal - clts_scale(speed_r, delay_r) - (stop_type ? stopadj_r : 32'h0) // R2 R3
                   : nominal; // R1
    // slow shift: speed squared over decel when adaptive, else a fixed decel distance
    assign slow_pt = ctrl_r[clts_pkg::CTRL_ADAPT_SLOW]
                   ? target - clts_scale(speed_r, speed_r / (decel_r | 16'h0001)) // R6
                   : target - {16'h0000, decel_r};

    // manual cycle allowed in halt always, in run only on flying machines
    assign cycle_ok   = !in_run || !stop_type; // R7 R8
    assign cycle_edge = CYCLE_BTN_IN && !btn_q_r;

    // apb phases
    assign setup  = PSEL_IN && !PENABLE_IN;
    assign access = PSEL_IN && PENABLE_IN;

    // button edge memory; resets to the released level, so a button held through reset reads as a press
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            btn_q_r <= 1'b0;
        end else begin
            btn_q_r <= CYCLE_BTN_IN;
        end
    end

    // encoder position, signed by direction; tracks through halt so nothing is lost
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pos_r <= 32'h0;
        end else if (ENC_STEP_IN) begin
            pos_r <= ENC_DIR_IN ? pos_r - 32'h1 : pos_r + 32'h1;
        end
    end

    // speed estimate: counts in a fixed window, latched each window
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tick_r    <= '0;
            win_cnt_r <= 16'h0;
            speed_r   <= 16'h0;
        end else if (tick_r == SAMPLE_CW_W'(SAMPLE_CYCLES - 1)) begin
            tick_r    <= '0; // R16
            // saturate rather than wrap: a wrapped count would look like a stopped line
            speed_r   <= (win_cnt_r == 16'hffff) ? win_cnt_r
                                                : win_cnt_r + {15'h0, ENC_STEP_IN}; // R16
            win_cnt_r <= 16'h0;
        end else begin
            tick_r    <= tick_r + 1'b1;
            if (ENC_STEP_IN && win_cnt_r != 16'hffff) begin
                win_cnt_r <= win_cnt_r + 16'h1;
            end
        end
    end

    // sequencer: halt has priority, faults force halt from anywhere
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_r <= clts_pkg::CLTS_HALT;
        end else if (fault || halt_cmd) begin
            state_r <= clts_pkg::CLTS_HALT; // R10 R13
        end else begin
            unique case (state_r)
                clts_pkg::CLTS_HALT: begin
                    if (run_cmd) begin
                        state_r <= two_speed ? clts_pkg::CLTS_RUN_FAST
                                             : clts_pkg::CLTS_RUN_SLOW; // R14
                    end
                end
                clts_pkg::CLTS_RUN_FAST: begin
                    if (stop_type && $signed(pos_r - slow_pt) >= 0) begin
                        state_r <= clts_pkg::CLTS_RUN_SLOW; // R6
                    end
                end
                clts_pkg::CLTS_RUN_SLOW: begin
                    if (stop_type && $signed(pos_r - target) >= 0) begin
                        state_r <= clts_pkg::CLTS_STOPPING; // R3
                    end
                end
                clts_pkg::CLTS_STOPPING: begin
                    if (tick_r == '0 && speed_r == 16'h0) begin
                        state_r <= clts_pkg::CLTS_SETTLE;
                    end
                end
                clts_pkg::CLTS_SETTLE: begin
                    state_r <= two_speed ? clts_pkg::CLTS_RUN_FAST
                                         : clts_pkg::CLTS_RUN_SLOW;
                end
            endcase
        end
    end

    // shear firing and part base advance
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SHEAR_OUT <= 1'b0;
            base_r    <= 32'h0;
        end else begin
            SHEAR_OUT <= 1'b0;
            if (state_r == clts_pkg::CLTS_SETTLE) begin
                SHEAR_OUT <= 1'b1; // R9
                base_r    <= nominal;
            end else if (in_run && !stop_type && $signed(pos_r - target) >= 0) begin
                SHEAR_OUT <= 1'b1; // R1 R2 R9
                base_r    <= nominal;
            end else if (cycle_edge && cycle_ok) begin
                SHEAR_OUT <= 1'b1; // R7 R8
                base_r    <= pos_r; // a manual cut zeroes the length count
            end
        end
    end

    // overshoot learning once the material is at rest
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            stopadj_r  <= 32'h0;
            over_r     <= 32'h0;
            accurate_r <= 1'b0;
        end else if (state_r == clts_pkg::CLTS_SETTLE) begin
            over_r <= pos_r - nominal; // R4
            if ($signed(pos_r - nominal) > $signed({16'h0, tol_r})) begin
                stopadj_r  <= stopadj_r + 32'h1; // R4 R5
                accurate_r <= 1'b0;
            end else if ($signed(nominal - pos_r) > $signed({16'h0, tol_r})) begin
                stopadj_r  <= (stopadj_r == 32'h0) ? 32'h0 : stopadj_r - 32'h1; // R4 R5
                accurate_r <= 1'b0;
            end else begin
                accurate_r <= 1'b1; // R5
            end
        end
    end

    // motion outputs; jog only in manual mode
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RUN_OUT  <= 1'b0;
            FWD_OUT  <= 1'b0;
            SLOW_OUT <= 1'b0;
            REV_OUT  <= 1'b0;
        end else begin
            RUN_OUT  <= in_run && !fault && !halt_cmd;
            FWD_OUT  <= (state_r == clts_pkg::CLTS_RUN_FAST) ||
                        (state_r == clts_pkg::CLTS_RUN_SLOW) ||
                        (!in_run && JOG_FWD_IN && !JOG_REV_IN); // R15
            SLOW_OUT <= (state_r == clts_pkg::CLTS_RUN_SLOW) ||
                        (!in_run && (JOG_FWD_IN ^ JOG_REV_IN)); // R15
            REV_OUT  <= !in_run && JOG_REV_IN && !JOG_FWD_IN; // R15
        end
    end

    // apb write side
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_r   <= clts_pkg::CTRL_RESET;
            length_r <= clts_pkg::LENGTH_RESET;
            delay_r  <= clts_pkg::DELAY_RESET;
            tol_r    <= clts_pkg::TOL_RESET;
            decel_r  <= clts_pkg::DECEL_RESET;
        end else if (access && PWRITE_IN) begin
            unique case (PADDR_IN)
                clts_pkg::OFF_CTRL:   ctrl_r   <= PWDATA_IN & 32'h0000_0037;
                clts_pkg::OFF_LENGTH: length_r <= PWDATA_IN;
                clts_pkg::OFF_DELAY:  delay_r  <= PWDATA_IN[15:0];
                clts_pkg::OFF_TOL:    tol_r    <= PWDATA_IN[15:0];
                clts_pkg::OFF_DECEL:  decel_r  <= PWDATA_IN[15:0];
                default: ;
            endcase
        end
    end

    // apb read side: zero wait states, data registered in setup
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PRDATA_OUT  <= 32'h0;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT  <= setup;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0;
            if (setup) begin
                unique case (PADDR_IN)
                    clts_pkg::OFF_CTRL:      PRDATA_OUT <= ctrl_r;
                    clts_pkg::OFF_LENGTH:    PRDATA_OUT <= length_r;
                    clts_pkg::OFF_DELAY:     PRDATA_OUT <= {16'h0, delay_r};
                    clts_pkg::OFF_TOL:       PRDATA_OUT <= {16'h0, tol_r};
                    clts_pkg::OFF_STATUS:    PRDATA_OUT <= {27'h0, accurate_r, 1'b0,
                                                            3'(state_r)};
                    clts_pkg::OFF_POSITION:  PRDATA_OUT <= pos_r;
                    clts_pkg::OFF_SPEED:     PRDATA_OUT <= {16'h0, speed_r};
                    clts_pkg::OFF_TARGET:    PRDATA_OUT <= target;
                    clts_pkg::OFF_STOPADJ:   PRDATA_OUT <= stopadj_r;
                    clts_pkg::OFF_DECEL:     PRDATA_OUT <= {16'h0, decel_r};
                    clts_pkg::OFF_OVERSHOOT: PRDATA_OUT <= over_r;
                    default:                 PSLVERR_OUT <= !PWRITE_IN; // unmapped read only
                endcase
            end
        end
    end
endmodule // clts_top

/* verification/clts_enc_model.sv */
`timescale 1ns/100ps
module clts_enc_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        go_in,
    input  wire logic        rev_in,
    input  wire logic [15:0] steps_in,
    input  wire logic [3:0]  gap_in,
    output logic             step_out,
    output logic             dir_out,
    output logic             busy_out
);
    logic [15:0] left_r;
    logic [3:0]  wait_r;
    // shaft turns only during a move; the line stands still between moves
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            left_r <= 16'h0;
            wait_r <= 4'h0;
            step_out <= 1'b0;
        end else if (go_in) begin
            left_r <= steps_in;
            wait_r <= 4'h0;
            step_out <= 1'b0;
        end else if (left_r != 16'h0 && wait_r == 4'h0) begin
            step_out <= 1'b1;
            left_r <= left_r - 16'h1;
            wait_r <= gap_in;
        end else begin
            step_out <= 1'b0;
            if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
        end
    end
    // direction is a plain level; busy covers the last count still on the wire
    assign dir_out = rev_in;
    assign busy_out = (left_r != 16'h0) || step_out;
endmodule // clts_enc_model

/* verification/clts_top_sva.sv */
`timescale 1ns/100ps
module clts_top_sva #(
    parameter int SAMPLE_CYCLES = 16
) (
    input wire logic        SYS_CLK_IN,
    input wire logic        RST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        CYCLE_BTN_IN,
    input wire logic        HALT_BTN_IN,
    input wire logic        REMOTE_HALT_IN,
    input wire logic        ESTOP_IN,
    input wire logic        OVERLOAD_IN,
    input wire logic        SHEAR_OUT,
    input wire logic        RUN_OUT,
    input wire logic        REV_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    // a bus request is a setup cycle answered in the following access cycle
    sequence s_setup;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence s_answer;
        PENABLE_IN && PREADY_OUT;
    endsequence
    chk_ready_after_setup: assert property (s_setup |=> s_answer)
        else $error("no ready one cycle after setup");
    chk_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    chk_error_read: assert property (PSLVERR_OUT |-> PREADY_OUT && !PWRITE_IN)
        else $error("error flag outside a read answer");
    chk_data_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data not zero between answers");
    chk_fault_halt: assert property (ESTOP_IN || OVERLOAD_IN |=> !RUN_OUT)
        else $error("run kept through a fault");
    chk_halt_cmd: assert property (HALT_BTN_IN || REMOTE_HALT_IN |=> !RUN_OUT)
        else $error("run kept through a halt command");
    chk_jog_run: assert property (RUN_OUT |-> !REV_OUT)
        else $error("reverse jog while running");
    // a cut outside run needs a recent manual cycle press
    chk_auto_run: assert property (SHEAR_OUT |-> RUN_OUT || $past(CYCLE_BTN_IN))
        else $error("cut outside run");
    chk_reset_quiet: assert property ($past(RST_IN) |-> !RUN_OUT && !SHEAR_OUT && !PREADY_OUT)
        else $error("outputs active after reset");
endmodule // clts_top_sva

bind clts_top clts_top_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) clts_top_sva_i (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .CYCLE_BTN_IN(CYCLE_BTN_IN), .HALT_BTN_IN(HALT_BTN_IN),
    .REMOTE_HALT_IN(REMOTE_HALT_IN), .ESTOP_IN(ESTOP_IN), .OVERLOAD_IN(OVERLOAD_IN),
    .SHEAR_OUT(SHEAR_OUT), .RUN_OUT(RUN_OUT), .REV_OUT(REV_OUT));

/* verification/tb.sv */
`timescale 1ns/100ps
module tb;
    localparam int SC = 16;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, len;
    logic [8:0]  sw;
    logic        go, step, dir, busy, shear, run_o, fwd_o, slow_o, rev_o;
    logic [15:0] steps;
    logic [3:0]  gap;
    logic [32:0] exp_q[$];
    int          miscompares, comparisons, shear_cnt, exp_shear;

    clts_top #(.SAMPLE_CYCLES(SC)) clts_top_i (
        .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ENC_STEP_IN(step), .ENC_DIR_IN(dir),
        .RUN_BTN_IN(sw[0]), .HALT_BTN_IN(sw[1]), .CYCLE_BTN_IN(sw[2]),
        .REMOTE_RUN_IN(sw[3]), .REMOTE_HALT_IN(sw[4]), .ESTOP_IN(sw[5]),
        .OVERLOAD_IN(sw[6]), .JOG_FWD_IN(sw[7]), .JOG_REV_IN(sw[8]), .SHEAR_OUT(shear),
        .RUN_OUT(run_o), .FWD_OUT(fwd_o), .SLOW_OUT(slow_o), .REV_OUT(rev_o));
    clts_enc_model clts_enc_model_i (.clk_in(clk), .rst_in(rst), .go_in(go), .rev_in(1'b0),
        .steps_in(steps), .gap_in(gap), .step_out(step), .dir_out(dir), .busy_out(busy));

    task automatic check(input logic [32:0] got, input logic [32:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bus transfer; a read leaves its expected {error, data} note in the queue
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        if (!w) exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        ticks(1);
        penable <= 1'b1;
        n = 0;
        do begin
            ticks(1);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        ticks(1);
    endtask
    // buttons are held one cycle, then outputs are given time to settle
    task automatic pulse(input int b);
        sw[b] <= 1'b1;
        ticks(1);
        sw[b] <= 1'b0;
        ticks(3);
    endtask
    task automatic start_move(input logic [15:0] s, input logic [3:0] g);
        steps <= s;
        gap <= g;
        go <= 1'b1;
        ticks(1);
        go <= 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            ticks(1);
            n++;
        end while (busy !== 1'b0 && n < 5000);
        if (busy !== 1'b0) begin
            miscompares++;
            print_verdict();
        end
        ticks(6);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // read answers are judged against the oldest note; every cut cycle is counted
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front(), "apb read");
        if (shear === 1'b1) shear_cnt++;
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, go} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sw = 9'h000;
        steps = 16'h0;
        gap = 4'h0;
        void'($urandom(32'h1da66363));
        ticks(4);
        rst <= 1'b0;
        ticks(1);
        apb(1'b0, clts_pkg::OFF_CTRL, 32'h0, {1'b0, clts_pkg::CTRL_RESET});
        apb(1'b0, clts_pkg::OFF_LENGTH, 32'h0, {1'b0, clts_pkg::LENGTH_RESET});
        apb(1'b0, clts_pkg::OFF_DECEL, 32'h0, {17'h0, clts_pkg::DECEL_RESET});
        apb(1'b0, 8'h3c, 32'h0, 33'h1_0000_0000);
        len = $urandom;
        apb(1'b1, clts_pkg::OFF_TOL, len, 33'h0);
        apb(1'b0, clts_pkg::OFF_TOL, 32'h0, {17'h0, len[15:0]});
        // three and a half parts fed in run give exactly three cuts
        len = 32'd20 + ($urandom % 16);
        apb(1'b1, clts_pkg::OFF_LENGTH, len, 33'h0);
        pulse(0);
        check(run_o, 1'b1, "run entered");
        start_move(16'(3 * len + len / 2), 4'h0);
        wait_idle();
        pulse(1);
        exp_shear = 3;
        check(run_o, 1'b0, "halt");
        check(shear_cnt, exp_shear, "cuts in run");
        // steady feed in halt, one count every other cycle, never cuts
        start_move(16'd200, 4'h1);
        ticks(60);
        apb(1'b0, clts_pkg::OFF_SPEED, 32'h0, 33'(SC / 2));
        wait_idle();
        check(shear_cnt, exp_shear, "no cut in halt");
        pulse(2);
        exp_shear++;
        check(shear_cnt, exp_shear, "manual cycle in halt");
        pulse(0);
        pulse(2);
        exp_shear++;
        check(shear_cnt, exp_shear, "crop while running");
        for (int b = 5; b < 7; b++) begin
            pulse(b);
            check(run_o, 1'b0, "fault halt");
            pulse(0);
        end
        pulse(1);
        sw[7] <= 1'b1;
        ticks(3);
        check({fwd_o, slow_o, rev_o}, 3'b110, "jog forward");
        sw[7] <= 1'b0;
        sw[8] <= 1'b1;
        ticks(3);
        check({fwd_o, slow_o, rev_o}, 3'b011, "jog reverse");
        pulse(0);
        check({run_o, rev_o}, 2'b10, "jog ignored in run");
        sw[8] <= 1'b0;
        pulse(1);
        // remote run: the panel button no longer starts the line
        apb(1'b1, clts_pkg::OFF_CTRL, 32'h0000_0004, 33'h0);
        pulse(0);
        check(run_o, 1'b0, "panel run ignored");
        pulse(3);
        check(run_o, 1'b1, "remote run");
        pulse(4);
        check(run_o, 1'b0, "remote halt");
        // feed-to-stop type: cycle refused in run, accepted in halt
        apb(1'b1, clts_pkg::OFF_CTRL, 32'h0000_0010, 33'h0);
        pulse(0);
        check({run_o, fwd_o, slow_o}, 3'b111, "single speed run");
        pulse(2);
        check(shear_cnt, exp_shear, "cycle refused in run");
        pulse(1);
        pulse(2);
        exp_shear++;
        check(shear_cnt, exp_shear, "cycle in halt");
        // flying cut with compensation: at 16 counts a window and delay 64 targets move in by 4
        apb(1'b1, clts_pkg::OFF_CTRL, 32'h0000_0001, 33'h0);
        apb(1'b1, clts_pkg::OFF_LENGTH, 32'h0000_0064, 33'h0);
        apb(1'b1, clts_pkg::OFF_DELAY, 32'h0000_0040, 33'h0);
        pulse(0);
        start_move(16'h00c6, 4'h0);
        wait_idle();
        exp_shear += 2;
        check(shear_cnt, exp_shear, "compensated cuts");
        pulse(1);
        // feed-to-stop: 5 counts of coast past the stop are learned as one count of advance
        apb(1'b1, clts_pkg::OFF_CTRL, 32'h0000_0010, 33'h0);
        apb(1'b1, clts_pkg::OFF_DELAY, 32'h0000_0000, 33'h0);
        apb(1'b1, clts_pkg::OFF_TOL, 32'h0000_0002, 33'h0);
        pulse(2);
        pulse(0);
        start_move(16'h0069, 4'h0);
        wait_idle();
        ticks(3 * SC);
        exp_shear += 2;
        check(shear_cnt, exp_shear, "cut at settle");
        apb(1'b0, clts_pkg::OFF_OVERSHOOT, 32'h0, 33'h0_0000_0005);
        apb(1'b0, clts_pkg::OFF_STOPADJ, 32'h0, 33'h0_0000_0001);
        apb(1'b0, clts_pkg::OFF_STATUS, 32'h0, 33'h0_0000_0002);
        // the learned advance stops one count early, so the coast lands on the cut point
        start_move(16'h005f, 4'h0);
        wait_idle();
        ticks(3 * SC);
        exp_shear++;
        check(shear_cnt, exp_shear, "second stop cut");
        apb(1'b0, clts_pkg::OFF_OVERSHOOT, 32'h0, 33'h0_0000_0000);
        apb(1'b0, clts_pkg::OFF_STATUS, 32'h0, 33'h0_0000_0012);
        pulse(1);
        check(exp_q.size(), 0, "reads answered");
        print_verdict();
    end
endmodule // tb
